/* rtl/iwt_pkg.sv */
// constants for the idle wakeup timer
`default_nettype none
package iwt_pkg;
    localparam int          CNT_W          = 16;
    localparam int          DIV_RATIO      = 10;
    localparam int          DIV_W          = 4;
    localparam int          ADDR_W         = 4;
    localparam int          DATA_W         = 8;
    localparam int          SEL_W          = 3;
    localparam int          SEL_BASE_BIT   = 11;
    localparam int          SEL_MAX_CODE   = 4;
    // register offsets
    localparam logic [3:0]  OFF_PERIOD_SEL = 4'h0;
    localparam logic [3:0]  OFF_IRQ_CTRL   = 4'h1;
    localparam logic [3:0]  OFF_IRQ_STAT   = 4'h2;
    localparam logic [3:0]  OFF_IRQ_CLR    = 4'h3;
    localparam logic [3:0]  OFF_IRQ_EN     = 4'h4;
    // irq control field positions
    localparam int          BIT_GIE        = 0;
    localparam int          BIT_TICK_EN    = 4;
    localparam int          BIT_TICK_PND   = 5;
    // status register bit positions
    localparam int          ST_TICK        = 0;
    localparam int          ST_WAKE        = 1;
    localparam int          ST_W           = 2;
    // reset values
    localparam logic [2:0]  SEL_RST        = 3'h0;
    localparam logic [15:0] CNT_RST        = 16'hffff;
    localparam logic [7:0]  RD_ZERO        = 8'h00;
endpackage
`default_nettype wire

/* rtl/iwt_cycle_div.sv */
// instruction cycle enable divider
`timescale 1ns/100ps
`default_nettype none
module iwt_cycle_div #(
    parameter int RATIO = iwt_pkg::DIV_RATIO
) (
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    output var  logic o_cyc_en
);
    logic [iwt_pkg::DIV_W-1:0] cnt_q;
    logic [iwt_pkg::DIV_W-1:0] cnt_d;
    wire                       wrap = (cnt_q == iwt_pkg::DIV_W'(RATIO - 1));

    assign cnt_d = wrap ? '0 : cnt_q + iwt_pkg::DIV_W'(1);

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            cnt_q    <= '0;
            o_cyc_en <= 1'b0;
        end else begin
            cnt_q    <= cnt_d;
            o_cyc_en <= wrap;
        end
    end
endmodule // iwt_cycle_div
`default_nettype wire

/* rtl/iwt_down_counter.sv */
// free-running idle down counter
`timescale 1ns/100ps
`default_nettype none
module iwt_down_counter #(
    parameter int WIDTH = iwt_pkg::CNT_W
) (
    input  wire logic             i_clk,
    input  wire logic             i_rst_n,
    input  wire logic             i_en,
    output var  logic [WIDTH-1:0] o_count
);
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_count <= '1;
        end else if (i_en) begin
            o_count <= o_count - WIDTH'(1);
        end
    end
endmodule // iwt_down_counter
`default_nettype wire

/* rtl/iwt_idle_timer.sv */
// idle wakeup timer top
//
// Design decisions made here: strobed register access and the address map.
`timescale 1ns/100ps
`default_nettype none
module iwt_idle_timer #(
    parameter int CNT_W = iwt_pkg::CNT_W
) (
    input  wire logic                       i_clk,
    input  wire logic                       i_rst_n,
    input  wire logic [iwt_pkg::ADDR_W-1:0] i_addr,
    input  wire logic [iwt_pkg::DATA_W-1:0] i_wdata,
    input  wire logic                       i_wr,
    input  wire logic                       i_rd,
    input  wire logic                       i_portg6_set,
    output var  logic [iwt_pkg::DATA_W-1:0] o_rdata,
    output var  logic                       o_tick_irq,
    output var  logic                       o_portg6,
    output var  logic                       o_cyc_en,
    output var  logic                       o_period_tick,
    output var  logic [CNT_W-1:0]           o_timebase,
    output var  logic                       o_irq
);
    // decode of the selected counter bit
    function automatic logic pick_bit(input logic [CNT_W-1:0] c,
                                      input logic [iwt_pkg::SEL_W-1:0] s);
        logic [iwt_pkg::SEL_W-1:0] k;
        k = (s > iwt_pkg::SEL_W'(iwt_pkg::SEL_MAX_CODE)) ?
            iwt_pkg::SEL_W'(iwt_pkg::SEL_MAX_CODE) : s;
        pick_bit = c[iwt_pkg::SEL_BASE_BIT + int'(k)];
    endfunction

    logic                        cyc_en;
    logic [CNT_W-1:0]            count;
    logic [iwt_pkg::SEL_W-1:0]   sel_q;
    logic                        pnd_q;
    logic                        ten_q;
    logic                        gie_q;
    logic [iwt_pkg::ST_W-1:0]    stat_q;
    logic [iwt_pkg::ST_W-1:0]    stat_d;
    logic [iwt_pkg::ST_W-1:0]    ien_q;
    logic                        prev_bit_q;
    logic                        g6_q;

    iwt_cycle_div #(
        .RATIO (iwt_pkg::DIV_RATIO)
    ) u_div (
        .i_clk    (i_clk),
        .i_rst_n  (i_rst_n),
        .o_cyc_en (cyc_en)
    );

    iwt_down_counter #(
        .WIDTH (CNT_W)
    ) u_cnt (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_en    (cyc_en),
        .o_count (count)
    );

    // address decode
    wire wr_sel  = i_wr && (i_addr == iwt_pkg::OFF_PERIOD_SEL);
    wire wr_ctl  = i_wr && (i_addr == iwt_pkg::OFF_IRQ_CTRL);
    wire wr_clr  = i_wr && (i_addr == iwt_pkg::OFF_IRQ_CLR);
    wire wr_ien  = i_wr && (i_addr == iwt_pkg::OFF_IRQ_EN);

    // underflow of selected bit, one to zero transition
    wire cur_bit = pick_bit(count, sel_q);
    wire uflow   = prev_bit_q && !cur_bit;

    // pending flag, set wins over software clear
    wire pnd_d   = uflow ? 1'b1 :
                   (wr_ctl ? i_wdata[iwt_pkg::BIT_TICK_PND] : pnd_q);

    // wake event clears port g bit 6
    wire g6_d    = uflow ? 1'b0 : (i_portg6_set ? 1'b1 : g6_q);

    wire irq_d   = pnd_d && ten_q && gie_q;

    // sticky status, set wins over clear
    wire [iwt_pkg::ST_W-1:0] ev = {uflow, uflow};
    assign stat_d = ev | (stat_q & ~(wr_clr ? i_wdata[iwt_pkg::ST_W-1:0] : '0));

    logic [iwt_pkg::DATA_W-1:0] rd_mux;
    always_comb begin
        rd_mux = iwt_pkg::RD_ZERO;
        case (i_addr)
            iwt_pkg::OFF_PERIOD_SEL: rd_mux[iwt_pkg::SEL_W-1:0] = sel_q;
            iwt_pkg::OFF_IRQ_CTRL: begin
                rd_mux[iwt_pkg::BIT_TICK_PND] = pnd_q;
                rd_mux[iwt_pkg::BIT_TICK_EN]  = ten_q;
                rd_mux[iwt_pkg::BIT_GIE]      = gie_q;
            end
            iwt_pkg::OFF_IRQ_STAT: rd_mux[iwt_pkg::ST_W-1:0] = stat_q;
            iwt_pkg::OFF_IRQ_EN:   rd_mux[iwt_pkg::ST_W-1:0] = ien_q;
            default:               rd_mux = iwt_pkg::RD_ZERO;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            sel_q         <= iwt_pkg::SEL_RST;
            pnd_q         <= 1'b0;
            ten_q         <= 1'b0;
            gie_q         <= 1'b0;
            stat_q        <= '0;
            ien_q         <= '0;
            prev_bit_q    <= 1'b1;
            g6_q          <= 1'b1;
            o_rdata       <= iwt_pkg::RD_ZERO;
            o_tick_irq    <= 1'b0;
            o_portg6      <= 1'b1;
            o_cyc_en      <= 1'b0;
            o_period_tick <= 1'b0;
            o_timebase    <= iwt_pkg::CNT_RST;
            o_irq         <= 1'b0;
        end else begin
            if (wr_sel) begin
                sel_q <= i_wdata[iwt_pkg::SEL_W-1:0];
            end
            if (wr_ctl) begin
                ten_q <= i_wdata[iwt_pkg::BIT_TICK_EN];
                gie_q <= i_wdata[iwt_pkg::BIT_GIE];
            end
            if (wr_ien) begin
                ien_q <= i_wdata[iwt_pkg::ST_W-1:0];
            end
            pnd_q         <= pnd_d;
            stat_q        <= stat_d;
            prev_bit_q    <= cur_bit;
            g6_q          <= g6_d;
            o_rdata       <= i_rd ? rd_mux : iwt_pkg::RD_ZERO;
            o_tick_irq    <= irq_d;
            o_portg6      <= g6_d;
            // time base for watchdog and start-up delays
            o_cyc_en      <= cyc_en;
            o_period_tick <= uflow;
            o_timebase    <= count;
            o_irq         <= |(stat_d & ien_q);
        end
    end
endmodule // iwt_idle_timer
`default_nettype wire

/* tb/iwt_idle_timer_asserts.sv */
// port checker for the idle wakeup timer
`timescale 1ns/100ps
`default_nettype none
module iwt_idle_timer_chk #(
    parameter int CNT_W = 16
) (
    input wire logic                       i_clk,
    input wire logic                       i_rst_n,
    input wire logic                       i_rd,
    input wire logic                       i_portg6_set,
    input wire logic [iwt_pkg::DATA_W-1:0] o_rdata,
    input wire logic                       o_portg6,
    input wire logic                       o_cyc_en,
    input wire logic                       o_period_tick,
    input wire logic [CNT_W-1:0]           o_timebase
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);
    chk_cyc_space: assert property (
        o_cyc_en |=> !o_cyc_en [*8] ##1 !o_cyc_en ##1 o_cyc_en)
        else $error("cycle enable spacing wrong");
    chk_count_step: assert property (
        $changed(o_timebase) |-> o_timebase == $past(o_timebase) - 1'b1)
        else $error("counter did not step down by one");
    chk_count_moves: assert property (
        o_cyc_en |-> ##[0:2] $changed(o_timebase))
        else $error("counter did not move on a cycle");
    chk_tick_wake: assert property (o_period_tick |-> !o_portg6)
        else $error("port bit not cleared on tick");
    chk_pg6_fall: assert property ($fell(o_portg6) |-> o_period_tick)
        else $error("port bit fell without tick");
    chk_pg6_rise: assert property ($rose(o_portg6) |-> $past(i_portg6_set))
        else $error("port bit rose without set");
    chk_tick_pulse: assert property (o_period_tick |=> !o_period_tick)
        else $error("tick longer than one clock");
    chk_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data outside read slot");
    chk_tick_on_step: assert property (o_period_tick |-> $past(o_cyc_en))
        else $error("tick without a counter step");
endmodule // iwt_idle_timer_chk
`default_nettype wire

/* tb/iwt_core_model.sv */
// core side model: idle entry and wake
`timescale 1ns/100ps
`default_nettype none
module iwt_core_model (
    input  wire logic i_clk,
    input  wire logic i_go_idle,
    input  wire logic i_portg6,
    output var  logic o_portg6_set = 1'b0,
    output var  logic o_idle = 1'b0
);
    always @(posedge i_clk) begin
        o_portg6_set <= i_go_idle;
        if (i_go_idle) begin
            o_idle <= 1'b1;
        end else if (!i_portg6 && !o_portg6_set) begin
            o_idle <= 1'b0;
        end
    end
endmodule // iwt_core_model
`default_nettype wire

/* tb/iwt_idle_timer_bench.sv */
// bench for the idle wakeup timer
`timescale 1ns/100ps
`default_nettype none
module iwt_idle_timer_bench;
    logic        i_clk = 1'b0;
    logic        i_rst_n = 1'b0;
    logic [3:0]  i_addr = 4'h0;
    logic [7:0]  i_wdata = 8'h00;
    logic        i_wr = 1'b0;
    logic        i_rd = 1'b0;
    logic        go_idle = 1'b0;
    logic        i_portg6_set, in_idle, o_tick_irq, o_portg6, o_cyc_en, o_period_tick, o_irq;
    logic [7:0]  o_rdata;
    logic [15:0] o_timebase;
    int          fails = 0;
    int          checks_done = 0;
    int          n;
    time         t0 = 0;
    iwt_idle_timer dut (.i_clk, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd, .i_portg6_set,
        .o_rdata, .o_tick_irq, .o_portg6, .o_cyc_en, .o_period_tick, .o_timebase, .o_irq);
    iwt_core_model core (.i_clk, .i_go_idle(go_idle), .i_portg6(o_portg6),
        .o_portg6_set(i_portg6_set), .o_idle(in_idle));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 chk(o_rdata, exp);
    endtask
    task automatic idle_req;
        @(posedge i_clk);
        go_idle <= 1'b1;
        @(posedge i_clk);
        go_idle <= 1'b0;
        repeat (2) @(posedge i_clk);
        #1;
    endtask
    task automatic print_verdict;
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        forever #10 i_clk = ~i_clk;
    end
    initial begin
        #1400000;
        fails++;
        print_verdict;
    end
    initial begin
        repeat (3) @(posedge i_clk);
        i_rst_n <= 1'b1;
        n = 0;
        rd(4'h0, 8'h00);
        rd(4'h1, 8'h00);
        rd(4'hf, 8'h00);
        for (int c = 0; c < 5; c++) begin
            wr(4'h0, 8'(c));
            rd(4'h0, 8'(c));
        end
        wr(4'h0, 8'h00);
        wr(4'h1, 8'h11);
        wr(4'h4, 8'h01);
        idle_req();
        chk(in_idle, 1'b1);
        n = 40;
        while (o_period_tick !== 1'b1 && n < 25000) begin
            @(posedge i_clk);
            #1;
            n++;
        end
        t0 = $time;
        chk(n > 20485 && n < 20496, 1'b1);
        chk(o_portg6, 1'b0);
        chk(o_tick_irq, 1'b1);
        chk(o_irq, 1'b1);
        rd(4'h1, 8'h31);
        chk(in_idle, 1'b0);
        rd(4'h2, 8'h03);
        wr(4'h1, 8'h01);
        chk(o_tick_irq, 1'b0);
        wr(4'h1, 8'h30);
        chk(o_tick_irq, 1'b0);
        wr(4'h1, 8'h31);
        @(posedge i_clk);
        #1;
        chk(o_tick_irq, 1'b1);
        wr(4'h3, 8'h01);
        chk(o_irq, 1'b0);
        rd(4'h2, 8'h02);
        idle_req();
        chk(o_portg6, 1'b1);
        chk(in_idle, 1'b1);
        n = 0;
        while (o_period_tick !== 1'b1 && n < 45000) begin
            @(posedge i_clk);
            #1;
            n++;
        end
        chk(16'(($time - t0) / 20), 16'ha000);
        @(posedge i_clk);
        #1;
        chk(in_idle, 1'b0);
        print_verdict;
    end
endmodule // iwt_idle_timer_bench
bind iwt_idle_timer iwt_idle_timer_chk #(.CNT_W(CNT_W)) u_chk (.i_clk, .i_rst_n, .i_rd,
    .i_portg6_set, .o_rdata, .o_portg6, .o_cyc_en, .o_period_tick, .o_timebase);
`default_nettype wire
